// ### sim/sebf_bus_master.sv
// Behavioural two-wire bus master that drives the clock and pulls the data line
`timescale 1ns/1ps
module sebf_bus_master #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic clk_in,
  // Bus lines
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  int unstable;

  // ==========================================
  // Line timing
  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
    unstable    = 0;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge clk_in);
  endtask

  // Released data, clock high, then data falls
  task automatic start_cond();
    sda_low_out <= 1'b0;
    wait_half();
    scl_out <= 1'b1;
    wait_half();
    sda_low_out <= 1'b1;
    wait_half();
    scl_out <= 1'b0;
    wait_half();
  endtask

  task automatic stop_cond();
    sda_low_out <= 1'b1;
    wait_half();
    scl_out <= 1'b1;
    wait_half();
    sda_low_out <= 1'b0;
    wait_half();
  endtask

  // One bit per pulse; data held across the whole high phase
  task automatic bit_io(input logic b, output logic seen);
    logic s0;
    sda_low_out <= !b;
    wait_half();
    scl_out <= 1'b1;
    @(posedge clk_in);
    s0 = sda_in;
    wait_half();
    seen = sda_in;
    if (s0 !== seen)
      unstable++;
    scl_out <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!ack, s);
  endtask
endmodule

// ### sim/sebf_top_tb.sv
// Self-checking bench for the two-wire bus slave front end
`include "sebf_cfg.svh"
`timescale 1ns/1ps
module sebf_top_tb;
  localparam int TWC = 400;
  logic       clk;
  logic       nrst;
  logic       scl;
  logic       m_low;
  logic       sda;
  logic       wp;
  logic [2:0] strap;
  logic [7:0] rd_data;
  logic       sda_out;
  logic       sda_oe;
  logic       wd_stb;
  logic       rd_stb;
  logic       wstart;
  logic       busy;
  logic       sel;
  logic       rmode;
  logic [13:0] waddr;
  logic [2:0] csel;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rb;
  int         err_count;
  int         total_checks;
  int         ws_cnt;
  int         rd_cnt;
  int         wd_cnt;
  int         busy_cyc;

  // Pull-up on the data line; either party may pull it low
  assign sda = !(m_low || (sda_oe && !sda_out));

  sebf_top #(.TWC_CYC(TWC)) u_dut (
    .CORE_CLK_IN(clk), .NRST_IN(nrst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_OUT(sda_oe), .CHIP_SEL_STRAP_BIT0_IN(strap[0]), .CHIP_SEL_STRAP_BIT1_IN(strap[1]),
    .CHIP_SEL_STRAP_BIT2_IN(strap[2]), .WP_IN(wp), .RD_DATA_IN(rd_data),
    .WORD_ADDRESS_BITS_OUT(waddr), .CHIP_SEL_OUT(csel), .WR_DATA_OUT(wdata),
    .WR_DATA_STB_OUT(wd_stb), .RD_NEXT_STB_OUT(rd_stb), .WRITE_START_OUT(wstart),
    .BUSY_OUT(busy), .SELECTED_OUT(sel), .READ_MODE_OUT(rmode));

  sebf_bus_master u_master (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));

  // ==========================================
  // Clock, monitors and pointer stand-in
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    ws_cnt   += (wstart === 1'b1);
    rd_cnt   += (rd_stb === 1'b1);
    wd_cnt   += (wd_stb === 1'b1);
    busy_cyc += (busy === 1'b1);
    if (sda_oe === 1'b1)
      check("sda_drive", sda_out, 1'b0);
    if (rd_stb === 1'b1)
      rd_data <= rd_data ^ 8'h55;
  end

  // ==========================================
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic ctrl(input logic [3:0] code, input logic [2:0] cs, input logic rw);
    u_master.start_cond();
    u_master.send_byte({code, cs, rw}, ack);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < TWC + 100 && busy === 1'b1; i++)
      @(posedge clk);
    check("busy_end", busy, 1'b0);
  endtask

  // Write with one data byte; protect level changed just before the Stop
  task automatic wr_txn(input logic wp_mid, input logic wp_stop);
    wp <= wp_mid;
    ctrl(`SEBF_DEV_CODE, 3'h5, 1'b0);
    check("ack_wp_ctrl", ack, 1'b1);
    u_master.send_byte(8'h00, ack);
    u_master.send_byte(8'h10, ack);
    u_master.send_byte(8'hA5, ack);
    check("ack_wp_data", ack, 1'b1);
    wp <= wp_stop;
    repeat (4) @(posedge clk);
    u_master.stop_cond();
  endtask

  // ==========================================
  // Watchdog
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run();
  end

  // ==========================================
  // Tests
  initial
  begin
    nrst = 1'b0;
    wp = 1'b0;
    strap = 3'h5;
    rd_data = 8'hC3;
    {err_count, total_checks, ws_cnt, rd_cnt, wd_cnt, busy_cyc} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("oe_reset", sda_oe, 1'b0);
    check("busy_reset", busy, 1'b0);
    repeat (4) @(posedge clk);
    ctrl(`SEBF_DEV_CODE, 3'h5, 1'b0);
    check("ack_ctrl", ack, 1'b1);
    check("selected", sel, 1'b1);
    check("read_mode", rmode, 1'b0);
    u_master.send_byte(8'hFF, ack);
    check("ack_addr_hi", ack, 1'b1);
    u_master.send_byte(8'h34, ack);
    check("word_addr", waddr, 14'h3F34);
    check("chip_sel", csel, 3'h5);
    u_master.send_byte(8'h5A, ack);
    check("ack_data", ack, 1'b1);
    check("wr_data", wdata, 8'h5A);
    check("wr_stb", wd_cnt, 1);
    u_master.stop_cond();
    check("deselect", sel, 1'b0);
    check("write_start", ws_cnt, 1);
    check("busy", busy, 1'b1);
    ctrl(`SEBF_DEV_CODE, 3'h5, 1'b0);
    check("ack_busy", ack, 1'b0);
    u_master.stop_cond();
    wait_idle();
    check("busy_len", busy_cyc, TWC);
    for (int i = 0; i < 4; i++)
    begin
      ctrl((i == 3) ? 4'h0 : `SEBF_DEV_CODE, 3'h5 ^ 3'(1 << i), 1'b0);
      check("ack_mismatch", ack, 1'b0);
      u_master.send_byte(8'h00, ack);
      check("ack_ignored", ack, 1'b0);
      check("sel_mismatch", sel, 1'b0);
      u_master.stop_cond();
    end
    wr_txn(1'b1, 1'b0);
    check("wp_stop_low", ws_cnt, 2);
    wait_idle();
    wr_txn(1'b0, 1'b1);
    check("wp_stop_high", ws_cnt, 2);
    check("busy_wp", busy, 1'b0);
    strap <= 3'h4;
    repeat (4) @(posedge clk);
    ctrl(`SEBF_DEV_CODE, 3'h4, 1'b1);
    check("ack_read", ack, 1'b1);
    check("read_mode", rmode, 1'b1);
    u_master.recv_byte(1'b1, rb);
    check("rd_byte0", rb, 8'hC3);
    check("rd_next", rd_cnt, 1);
    u_master.recv_byte(1'b0, rb);
    check("rd_byte1", rb, 8'h96);
    repeat (6) @(posedge clk);
    check("released", sda_oe, 1'b0);
    check("rd_nack", rd_cnt, 1);
    u_master.stop_cond();
    check("stable_high", u_master.unstable, 0);
    complete_run();
  end
endmodule

// ### src/sebf_cfg.svh
// Constants for the serial EEPROM bus slave front end
`ifndef SEBF_CFG_SVH
`define SEBF_CFG_SVH
// Device-type code; the value is arbitrary
`define SEBF_DEV_CODE      4'h6
`define SEBF_ADDR_W        14
`define SEBF_TWC_MS        5
`define SEBF_CLK_MHZ       100
`define SEBF_TWC_CYC       (`SEBF_TWC_MS * 1000 * `SEBF_CLK_MHZ)
`define SEBF_TWC_W         20
`endif

// ### src/sebf_pkg.sv
// Types for the serial EEPROM bus slave front end
package sebf_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CTRL  = 6'h02,
    ST_ADRH  = 6'h04,
    ST_ADRL  = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } sebf_state_t;
endpackage

// ### src/sebf_sync.sv
// Two-flip-flop synchroniser for one pin
`timescale 1ns/1ps
module sebf_sync (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_reg;
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta_reg <= 1'b1;
      q_out    <= 1'b1;
    end
    else
    begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// ### src/sebf_top.sv
// Two-wire bus slave front end of a serial EEPROM
`include "sebf_cfg.svh"
`timescale 1ns/1ps
module sebf_top #(
  parameter int TWC_CYC = `SEBF_TWC_CYC
) (
  // Clock and reset
  input  wire logic                    CORE_CLK_IN,
  input  wire logic                    NRST_IN,
  // Serial bus pins
  input  wire logic                    SCL_IN,
  input  wire logic                    SDA_IN,
  output logic                         SDA_OUT,
  output logic                         SDA_OE_OUT,
  // Straps
  input  wire logic                    CHIP_SEL_STRAP_BIT0_IN,
  input  wire logic                    CHIP_SEL_STRAP_BIT1_IN,
  input  wire logic                    CHIP_SEL_STRAP_BIT2_IN,
  input  wire logic                    WP_IN,
  // Read data from the array side
  input  wire logic [7:0]              RD_DATA_IN,
  // Array side
  output logic [`SEBF_ADDR_W-1:0]      WORD_ADDRESS_BITS_OUT,
  output logic [2:0]                   CHIP_SEL_OUT,
  output logic [7:0]                   WR_DATA_OUT,
  output logic                         WR_DATA_STB_OUT,
  output logic                         RD_NEXT_STB_OUT,
  output logic                         WRITE_START_OUT,
  output logic                         BUSY_OUT,
  output logic                         SELECTED_OUT,
  output logic                         READ_MODE_OUT
);

  // ==========================================================
  // Pin synchronisers and condition detection
  logic scl_s, sda_s, wp_s, cs0_s, cs1_s, cs2_s;
  logic scl_d_reg, sda_d_reg, scl_fall_d_reg;
  logic busy;

  sebf_sync u_scl (.clk_in(CORE_CLK_IN), .nrst_in(NRST_IN), .d_in(SCL_IN), .q_out(scl_s));
  sebf_sync u_sda (.clk_in(CORE_CLK_IN), .nrst_in(NRST_IN), .d_in(SDA_IN), .q_out(sda_s));
  sebf_sync u_wp  (.clk_in(CORE_CLK_IN), .nrst_in(NRST_IN), .d_in(WP_IN), .q_out(wp_s));
  sebf_sync u_cs0 (.clk_in(CORE_CLK_IN), .nrst_in(NRST_IN), .d_in(CHIP_SEL_STRAP_BIT0_IN), .q_out(cs0_s));
  sebf_sync u_cs1 (.clk_in(CORE_CLK_IN), .nrst_in(NRST_IN), .d_in(CHIP_SEL_STRAP_BIT1_IN), .q_out(cs1_s));
  sebf_sync u_cs2 (.clk_in(CORE_CLK_IN), .nrst_in(NRST_IN), .d_in(CHIP_SEL_STRAP_BIT2_IN), .q_out(cs2_s));

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      scl_d_reg      <= 1'b1;
      sda_d_reg      <= 1'b1;
      scl_fall_d_reg <= 1'b0;
    end
    else
    begin
      scl_d_reg      <= scl_s;
      sda_d_reg      <= sda_s;
      scl_fall_d_reg <= !scl_s && scl_d_reg;
    end
  end

  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign scl_rise  = scl_s && !scl_d_reg;
  assign scl_fall  = !scl_s && scl_d_reg;

  // ==========================================================
  // Bit and byte sequencing
  sebf_pkg::sebf_state_t state_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic       wr_cmd_reg;
  logic       got_data_reg;
  logic       ack_phase;
  logic       ctrl_match;
  logic [7:0] byte_in;

  assign ack_phase = (bit_reg == 4'h8);
  assign byte_in   = {shift_reg[6:0], sda_s};
  assign ctrl_match = (shift_reg[6:3] == `SEBF_DEV_CODE) &&
                      (shift_reg[2:0] == {cs2_s, cs1_s, cs0_s});

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      shift_reg <= 8'h00;
    else if (scl_rise && !ack_phase)
      shift_reg <= byte_in;
  end

  // The SCL fall that ends a Start hold closes no bit
  logic start_hold_reg;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      start_hold_reg <= 1'b0;
    else if (start_det)
      start_hold_reg <= 1'b1;
    else if (scl_fall)
      start_hold_reg <= 1'b0;
  end

  // Bit counter: 0..7 data bits, 8 the acknowledge slot
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      bit_reg <= 4'h0;
    else if (start_det)
      bit_reg <= 4'h0;
    else if (scl_fall && state_reg != sebf_pkg::ST_IDLE && !start_hold_reg)
      bit_reg <= ack_phase ? 4'h0 : bit_reg + 4'h1;
  end

  // Pending acknowledge and master acknowledge capture
  logic ack_pend_reg;
  logic master_ack_reg;
  logic nack_seen_reg;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      state_reg     <= sebf_pkg::ST_IDLE;
      wr_cmd_reg    <= 1'b0;
      ack_pend_reg  <= 1'b0;
      SELECTED_OUT  <= 1'b0;
      READ_MODE_OUT <= 1'b0;
      CHIP_SEL_OUT  <= 3'h0;
    end
    else if (stop_det)
    begin
      state_reg    <= sebf_pkg::ST_IDLE;
      ack_pend_reg <= 1'b0;
      SELECTED_OUT <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg    <= sebf_pkg::ST_CTRL;
      ack_pend_reg <= 1'b0;
      SELECTED_OUT <= 1'b0;
    end
    else if (scl_rise && bit_reg == 4'h7)
    begin
      case (state_reg)
        sebf_pkg::ST_CTRL:
        begin
          if (ctrl_match && !busy)
          begin
            ack_pend_reg  <= 1'b1;
            SELECTED_OUT  <= 1'b1;
            CHIP_SEL_OUT  <= shift_reg[2:0];
            READ_MODE_OUT <= sda_s;
            wr_cmd_reg    <= !sda_s;
            state_reg     <= sda_s ? sebf_pkg::ST_RDATA : sebf_pkg::ST_ADRH;
          end
          else
            state_reg <= sebf_pkg::ST_IDLE;
        end
        sebf_pkg::ST_ADRH:
        begin
          ack_pend_reg <= 1'b1;
          state_reg    <= sebf_pkg::ST_ADRL;
        end
        sebf_pkg::ST_ADRL:
        begin
          ack_pend_reg <= 1'b1;
          state_reg    <= sebf_pkg::ST_WDATA;
        end
        sebf_pkg::ST_WDATA:
          ack_pend_reg <= 1'b1;
        sebf_pkg::ST_RDATA:
          ack_pend_reg <= 1'b0;
        default:
          state_reg <= sebf_pkg::ST_IDLE;
      endcase
    end
    else if (scl_fall && ack_phase)
      ack_pend_reg <= 1'b0;
    else if (nack_seen_reg && state_reg == sebf_pkg::ST_RDATA)
      state_reg <= sebf_pkg::ST_IDLE;
  end

  // Master acknowledge sampled at the ninth rising edge of a read byte
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      master_ack_reg <= 1'b0;
      nack_seen_reg  <= 1'b0;
    end
    else
    begin
      master_ack_reg <= 1'b0;
      nack_seen_reg  <= 1'b0;
      if (scl_rise && ack_phase && state_reg == sebf_pkg::ST_RDATA && !ack_pend_reg)
      begin
        master_ack_reg <= !sda_s;
        nack_seen_reg  <= sda_s;
      end
    end
  end

  // ==========================================================
  // Address pointer, write data and strobes
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      WORD_ADDRESS_BITS_OUT <= '0;
      WR_DATA_OUT           <= 8'h00;
      WR_DATA_STB_OUT       <= 1'b0;
      RD_NEXT_STB_OUT       <= 1'b0;
      got_data_reg          <= 1'b0;
    end
    else
    begin
      WR_DATA_STB_OUT <= 1'b0;
      RD_NEXT_STB_OUT <= master_ack_reg;
      if (start_det)
        got_data_reg <= 1'b0;
      if (scl_rise && bit_reg == 4'h7)
      begin
        case (state_reg)
          sebf_pkg::ST_ADRH:
            WORD_ADDRESS_BITS_OUT[13:8] <= byte_in[5:0];
          sebf_pkg::ST_ADRL:
            WORD_ADDRESS_BITS_OUT[7:0] <= byte_in;
          sebf_pkg::ST_WDATA:
          begin
            WR_DATA_OUT     <= byte_in;
            WR_DATA_STB_OUT <= 1'b1;
            got_data_reg    <= 1'b1;
          end
          default:
            got_data_reg <= got_data_reg;
        endcase
      end
    end
  end

  // Write cycle launches at Stop only with data and protect low
  logic write_go;
  assign write_go = stop_det && wr_cmd_reg && got_data_reg &&
                    state_reg == sebf_pkg::ST_WDATA && !wp_s;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      WRITE_START_OUT <= 1'b0;
    else
      WRITE_START_OUT <= write_go;
  end

  sebf_wtimer #(.TWC_CYC(TWC_CYC)) u_wt (
    .clk_in   (CORE_CLK_IN),
    .nrst_in  (NRST_IN),
    .go_in    (write_go),
    .busy_out (busy)
  );

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      BUSY_OUT <= 1'b0;
    else
      BUSY_OUT <= busy;
  end

  // ==========================================================
  // Open-drain data driver
  logic [7:0] tx_reg;
  logic       pull_low;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      tx_reg <= 8'hFF;
    else if (state_reg == sebf_pkg::ST_RDATA && scl_fall && ack_phase)
      tx_reg <= RD_DATA_IN;
    else if (state_reg == sebf_pkg::ST_RDATA && scl_fall && !ack_phase && bit_reg != 4'h7)
      tx_reg <= {tx_reg[6:0], 1'b1};
  end

  always_comb
  begin
    pull_low = 1'b0;
    if (ack_pend_reg && ack_phase)
      pull_low = 1'b1;
    else if (state_reg == sebf_pkg::ST_RDATA && !ack_phase && !ack_pend_reg)
      pull_low = !tx_reg[7];
  end

  // Drive changes follow SCL falling, so SDA moves while SCL is low; Start, Stop and a master not-acknowledge also update it
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      SDA_OE_OUT <= 1'b0;
      SDA_OUT    <= 1'b0;
    end
    else
    begin
      SDA_OUT <= 1'b0;
      // One cycle after the fall, so the bit counter already names the new bit
      if (scl_fall_d_reg || start_det || stop_det || nack_seen_reg)
        SDA_OE_OUT <= pull_low && !stop_det && !start_det;
    end
  end

  // ==========================================================
  // Checks
  od_never_high_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) SDA_OUT == 1'b0)
    else $error("SDA driven high");
  busy_no_ack_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (busy && state_reg == sebf_pkg::ST_CTRL && scl_rise && bit_reg == 4'h7) |=> !ack_pend_reg && !SELECTED_OUT)
    else $error("ack during write cycle");
  mismatch_idle_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (state_reg == sebf_pkg::ST_CTRL && scl_rise && bit_reg == 4'h7 && !ctrl_match) |=> !ack_pend_reg)
    else $error("ack on mismatched control");
  wp_block_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (stop_det && wp_s) |=> !WRITE_START_OUT)
    else $error("write started while protected");
  write_busy_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    write_go |=> busy ##1 BUSY_OUT)
    else $error("busy missing after write start");
  oe_steady_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (scl_s && scl_d_reg && !start_det && !stop_det && !nack_seen_reg) |=> $stable(SDA_OE_OUT))
    else $error("SDA drive changed while SCL high");
  start_ctrl_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    start_det |=> state_reg == sebf_pkg::ST_CTRL && bit_reg == 4'h0)
    else $error("start not taken");
  stop_idle_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    stop_det |=> state_reg == sebf_pkg::ST_IDLE && !SDA_OE_OUT)
    else $error("stop not taken");
  ack_drive_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (ack_pend_reg && ack_phase && scl_fall_d_reg && !start_det && !stop_det) |=> SDA_OE_OUT)
    else $error("acknowledge not driven");
  rd_next_stb_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (scl_rise && ack_phase && state_reg == sebf_pkg::ST_RDATA && !ack_pend_reg && !sda_s) |-> ##2 RD_NEXT_STB_OUT)
    else $error("read advance missing");
  nack_release_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (nack_seen_reg && !start_det && !stop_det) |=> state_reg == sebf_pkg::ST_IDLE && !SDA_OE_OUT)
    else $error("data line held after master not-acknowledge");
  start_bit_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (start_hold_reg && scl_fall && !start_det) |=> bit_reg == 4'h0)
    else $error("bit counted on Start hold fall");
endmodule

// ### src/sebf_wtimer.sv
// Self-timed write cycle counter, busy while running
`include "sebf_cfg.svh"
`timescale 1ns/1ps
module sebf_wtimer #(
  parameter int TWC_CYC = `SEBF_TWC_CYC
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic go_in,
  output logic      busy_out
);
  logic [`SEBF_TWC_W-1:0] cnt_reg;
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt_reg  <= '0;
      busy_out <= 1'b0;
    end
    else if (go_in && !busy_out)
    begin
      cnt_reg  <= `SEBF_TWC_W'(TWC_CYC - 1);
      busy_out <= 1'b1;
    end
    else if (busy_out)
    begin
      if (cnt_reg == '0)
        busy_out <= 1'b0;
      else
        cnt_reg <= cnt_reg - `SEBF_TWC_W'(1);
    end
  end
endmodule
